// File: design/memory_map_pkg.sv
// Purpose: Shared constants for the memory map and stack pointer block.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Offsets are special-function or RAM byte addresses.
// Contract
// - External-access pin low at reset selects external code; otherwise internal flash.
// - Internal execution never rolls over from F7FFH into external code at F800H.
// - Internal mode fetches from F800H through FFFFH return the no-operation opcode.
// - Lower 128 RAM bytes answer both direct and indirect addressing.
// - Upper 128 RAM bytes only indirect; direct accesses go to special-function space.
// - Lowest 32 RAM bytes are four banks of eight working registers.
// - Bytes 20H to 2FH are also 128 single bits at bit addresses 00H-7FH.
// - Reset sets stack pointer to 07H so first push lands at 08H.
// - Extended stack off by default; pointer wraps FFH to 00H in RAM.
// - Core configuration bit 7 enables 11-bit pointer continuing into extended RAM.
// - Pointer low byte at 81H; high byte at B7H, three low bits used.
// - Up to 1792 extended RAM bytes serve as stack, 2048 bytes deep total.
// - Push increments the pointer before writing the data.
package memory_map_pkg;

  localparam logic [7:0] SP_LOW_ADDR = 8'h81;
  localparam logic [7:0] SP_HIGH_ADDR = 8'hB7;
  localparam logic [7:0] CORE_CONFIG_ADDR = 8'hAF;

  localparam logic [7:0] SP_LOW_RESET = 8'h07;
  localparam logic [2:0] SP_HIGH_RESET = 3'h0;
  localparam logic [7:0] CORE_CONFIG_RESET = 8'h00;
  localparam int EXT_STACK_BIT = 7;

  localparam int SP_WIDTH = 11;
  localparam int SP_HIGH_BITS = 3;
  localparam logic [10:0] EXTENDED_DATA_RAM_STACK_BASE = 11'h100;

  localparam logic [7:0] NOP_OPCODE = 8'h00;
  localparam logic [15:0] NOP_AREA_BASE = 16'hF800;

  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  localparam int UPPER_HALF_BIT = 7;

  typedef enum logic [1:0]
  {
    ACCESS_DIRECT = 2'b00,
    ACCESS_INDIRECT = 2'b01,
    ACCESS_BANK_REG = 2'b10
  } access_mode_e;

endpackage

// File: design/stack_ctrl_if.sv
// Purpose: Carrier between the memory map and the stack pointer unit.
// Assumes: Single clock; strobes are one-cycle.
// Notes: Addresses are 11 bits even in default mode.
`timescale 1ns/1ps
`default_nettype none
interface stack_ctrl_if;
  logic inc;
  logic dec;
  logic wr_low;
  logic wr_high;
  logic [7:0] wdata;
  logic ext_en;
  logic [7:0] sp_low;
  logic [2:0] sp_high;
  logic [10:0] cur_addr;
  logic [10:0] next_addr;

  modport core
  (
    output inc, dec, wr_low, wr_high, wdata, ext_en,
    input sp_low, sp_high, cur_addr, next_addr
  );

  modport unit
  (
    input inc, dec, wr_low, wr_high, wdata, ext_en,
    output sp_low, sp_high, cur_addr, next_addr
  );
endinterface
`default_nettype wire

// File: design/stack_pointer_unit.sv
// Purpose: Stack pointer low byte, three extra high bits and address arithmetic.
// Assumes: At most one of inc, dec, wr_low, wr_high per cycle except both writes.
// Notes: Only three high bits are stored; the rest of that byte reads zero.
`timescale 1ns/1ps
`default_nettype none
module stack_pointer_unit
(
  input wire logic clock,
  input wire logic sys_rst,
  stack_ctrl_if.unit sp
);

  logic [7:0] sp_low;
  logic [2:0] sp_high;
  logic [10:0] wide_ptr;
  logic [10:0] wide_inc;
  logic [10:0] wide_dec;
  logic [7:0] low_inc;
  logic [7:0] low_dec;

  assign wide_ptr = {sp_high, sp_low};
  assign wide_inc = wide_ptr + 11'h001;
  assign wide_dec = wide_ptr - 11'h001;
  assign low_inc = sp_low + 8'h01;
  assign low_dec = sp_low - 8'h01;

  // Default mode keeps the pointer inside the 256-byte RAM
  assign sp.cur_addr = sp.ext_en ? wide_ptr : {3'h0, sp_low};
  assign sp.next_addr = sp.ext_en ? wide_inc : {3'h0, low_inc};
  assign sp.sp_low = sp_low;
  assign sp.sp_high = sp_high;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sp_low <= memory_map_pkg::SP_LOW_RESET;
    end
    else if (sp.wr_low)
    begin
      sp_low <= sp.wdata;
    end
    else if (sp.inc)
    begin
      sp_low <= sp.ext_en ? wide_inc[7:0] : low_inc;
    end
    else if (sp.dec)
    begin
      sp_low <= sp.ext_en ? wide_dec[7:0] : low_dec;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sp_high <= memory_map_pkg::SP_HIGH_RESET;
    end
    else if (sp.wr_high)
    begin
      sp_high <= sp.wdata[2:0];
    end
    else if (sp.inc && sp.ext_en)
    begin
      sp_high <= wide_inc[10:8];
    end
    else if (sp.dec && sp.ext_en)
    begin
      sp_high <= wide_dec[10:8];
    end
  end

endmodule
`default_nettype wire

// File: design/memory_map_stack.sv
// Purpose: Code-space selection, internal RAM decode, bit area and stack storage.
// Assumes: Code and RAM read data inputs are valid in the request cycle.
// Notes: One data request is served per cycle; stack beats memory beats bit access.
`timescale 1ns/1ps
`default_nettype none
module memory_map_stack #(
  parameter int IRAM_DEPTH = 256,
  parameter int EXTENDED_DATA_RAM_DEPTH = 2048
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ext_code_select_n,
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  input wire logic [7:0] flash_rdata,
  input wire logic [7:0] ext_code_rdata,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [1:0] mem_mode,
  input wire logic [1:0] mem_bank,
  input wire logic [7:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic bit_req,
  input wire logic bit_we,
  input wire logic [6:0] bit_addr,
  input wire logic bit_wdata,
  input wire logic push_req,
  input wire logic [7:0] push_data,
  input wire logic pop_req,
  output logic code_external,
  output logic fetch_valid,
  output logic [7:0] fetch_data,
  output logic fetch_in_nop_area,
  output logic mem_rvalid,
  output logic [7:0] mem_rdata,
  output logic sfr_fwd_req,
  output logic sfr_fwd_we,
  output logic [7:0] sfr_fwd_addr,
  output logic [7:0] sfr_fwd_wdata,
  output logic bit_rvalid,
  output logic bit_rdata,
  output logic pop_valid,
  output logic [7:0] pop_data,
  output logic stack_in_extended_data_ram
);

  if (IRAM_DEPTH != 256 || EXTENDED_DATA_RAM_DEPTH < 256 || EXTENDED_DATA_RAM_DEPTH > 2048)
  begin : g_depth_check
    $error("memory_map_stack: unsupported RAM depth");
  end

  stack_ctrl_if spif();

  stack_pointer_unit u_stack_pointer
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .sp(spif.unit)
  );

  logic [7:0] iram [IRAM_DEPTH];
  logic [7:0] extended_data_ram [EXTENDED_DATA_RAM_DEPTH];
  logic [7:0] core_config_reg;

  logic stack_go;
  logic push_go;
  logic pop_go;
  logic mem_go;
  logic bit_go;
  logic [10:0] stack_addr;
  logic stack_hits_extended_data_ram;
  logic [7:0] mem_eff_addr;
  logic mem_to_sfr;
  logic own_sp_low;
  logic own_sp_high;
  logic own_config;
  logic [7:0] bit_byte_addr;
  logic [7:0] bit_byte;
  logic [7:0] bit_mask;
  logic iram_we;
  logic [7:0] iram_waddr;
  logic [7:0] iram_wdata;
  logic extended_data_ram_we;
  logic [10:0] extended_data_ram_waddr;
  logic [7:0] next_mem_rdata;
  logic [7:0] next_fetch_data;
  logic fetch_nop;

  // Arbitration: a refused request gets no answer
  assign push_go = push_req;
  assign pop_go = pop_req && !push_req;
  assign stack_go = push_go || pop_go;
  assign mem_go = mem_req && !stack_go;
  assign bit_go = bit_req && !stack_go && !mem_req;

  // Push targets the incremented pointer, pop reads the current one
  assign stack_addr = push_go ? spif.next_addr : spif.cur_addr;
  assign stack_hits_extended_data_ram = stack_addr >= memory_map_pkg::EXTENDED_DATA_RAM_STACK_BASE;

  always_comb
  begin
    mem_eff_addr = mem_addr;
    mem_to_sfr = 1'b0;
    case (mem_mode)
      memory_map_pkg::ACCESS_DIRECT:
      begin
        mem_eff_addr = mem_addr;
        mem_to_sfr = mem_addr[memory_map_pkg::UPPER_HALF_BIT];
      end
      memory_map_pkg::ACCESS_INDIRECT:
      begin
        mem_eff_addr = mem_addr;
        mem_to_sfr = 1'b0;
      end
      memory_map_pkg::ACCESS_BANK_REG:
      begin
        mem_eff_addr = {3'h0, mem_bank, mem_addr[2:0]};
        mem_to_sfr = 1'b0;
      end
      default:
      begin
        mem_eff_addr = mem_addr;
        mem_to_sfr = 1'b0;
      end
    endcase
  end

  assign own_sp_low = mem_to_sfr && (mem_addr == memory_map_pkg::SP_LOW_ADDR);
  assign own_sp_high = mem_to_sfr && (mem_addr == memory_map_pkg::SP_HIGH_ADDR);
  assign own_config = mem_to_sfr && (mem_addr == memory_map_pkg::CORE_CONFIG_ADDR);

  // Bit area: sixteen bytes, eight bits each
  assign bit_byte_addr = memory_map_pkg::BIT_AREA_BASE + {4'h0, bit_addr[6:3]};
  assign bit_byte = iram[bit_byte_addr];
  assign bit_mask = 8'h01 << bit_addr[2:0];

  always_comb
  begin
    iram_we = 1'b0;
    iram_waddr = 8'h00;
    iram_wdata = 8'h00;
    extended_data_ram_we = 1'b0;
    extended_data_ram_waddr = 11'h000;
    if (push_go)
    begin
      iram_we = !stack_hits_extended_data_ram;
      iram_waddr = stack_addr[7:0];
      iram_wdata = push_data;
      extended_data_ram_we = stack_hits_extended_data_ram;
      extended_data_ram_waddr = stack_addr;
    end
    else if (mem_go && mem_we && !mem_to_sfr)
    begin
      iram_we = 1'b1;
      iram_waddr = mem_eff_addr;
      iram_wdata = mem_wdata;
    end
    else if (bit_go && bit_we)
    begin
      iram_we = 1'b1;
      iram_waddr = bit_byte_addr;
      iram_wdata = bit_wdata ? (bit_byte | bit_mask) : (bit_byte & ~bit_mask);
    end
  end

  always_ff @(posedge clock)
  begin
    if (iram_we)
    begin
      iram[iram_waddr] <= iram_wdata;
    end
  end

  // Extended RAM below the stack base is never touched here
  always_ff @(posedge clock)
  begin
    if (extended_data_ram_we && (int'(extended_data_ram_waddr) < EXTENDED_DATA_RAM_DEPTH))
    begin
      extended_data_ram[extended_data_ram_waddr] <= push_data;
    end
  end

  // Pointer control towards the unit
  assign spif.ext_en = core_config_reg[memory_map_pkg::EXT_STACK_BIT];
  assign spif.inc = push_go;
  assign spif.dec = pop_go;
  assign spif.wr_low = mem_go && mem_we && own_sp_low;
  assign spif.wr_high = mem_go && mem_we && own_sp_high;
  assign spif.wdata = mem_wdata;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      core_config_reg <= memory_map_pkg::CORE_CONFIG_RESET;
    end
    else if (mem_go && mem_we && own_config)
    begin
      core_config_reg <= mem_wdata;
    end
  end

  always_comb
  begin
    next_mem_rdata = 8'h00;
    if (!mem_to_sfr)
    begin
      next_mem_rdata = iram[mem_eff_addr];
    end
    else if (own_sp_low)
    begin
      next_mem_rdata = spif.sp_low;
    end
    else if (own_sp_high)
    begin
      next_mem_rdata = {5'h00, spif.sp_high};
    end
    else if (own_config)
    begin
      next_mem_rdata = core_config_reg;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      mem_rvalid <= 1'b0;
      mem_rdata <= 8'h00;
    end
    else
    begin
      mem_rvalid <= mem_go && !mem_we;
      mem_rdata <= (mem_go && !mem_we) ? next_mem_rdata : mem_rdata;
    end
  end

  // Direct upper-half accesses that are not ours leave the block
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sfr_fwd_req <= 1'b0;
      sfr_fwd_we <= 1'b0;
      sfr_fwd_addr <= 8'h00;
      sfr_fwd_wdata <= 8'h00;
    end
    else
    begin
      sfr_fwd_req <= mem_go && mem_to_sfr && !own_sp_low && !own_sp_high && !own_config;
      sfr_fwd_we <= mem_go && mem_we;
      sfr_fwd_addr <= mem_go ? mem_addr : sfr_fwd_addr;
      sfr_fwd_wdata <= mem_go ? mem_wdata : sfr_fwd_wdata;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      bit_rvalid <= 1'b0;
      bit_rdata <= 1'b0;
    end
    else
    begin
      bit_rvalid <= bit_go && !bit_we;
      bit_rdata <= (bit_go && !bit_we) ? bit_byte[bit_addr[2:0]] : bit_rdata;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      pop_valid <= 1'b0;
      pop_data <= 8'h00;
      stack_in_extended_data_ram <= 1'b0;
    end
    else
    begin
      pop_valid <= pop_go;
      if (pop_go)
      begin
        pop_data <= stack_hits_extended_data_ram ? extended_data_ram[stack_addr] : iram[stack_addr[7:0]];
      end
      stack_in_extended_data_ram <= spif.ext_en && (spif.cur_addr >= memory_map_pkg::EXTENDED_DATA_RAM_STACK_BASE);
    end
  end

  // Strap is sampled on every reset cycle and held once reset drops
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      code_external <= !ext_code_select_n;
    end
  end

  // The top 2 KB never reaches external code while running internally
  assign fetch_nop = !code_external && (fetch_addr >= memory_map_pkg::NOP_AREA_BASE);

  always_comb
  begin
    if (code_external)
    begin
      next_fetch_data = ext_code_rdata;
    end
    else if (fetch_nop)
    begin
      next_fetch_data = memory_map_pkg::NOP_OPCODE;
    end
    else
    begin
      next_fetch_data = flash_rdata;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      fetch_valid <= 1'b0;
      fetch_data <= 8'h00;
      fetch_in_nop_area <= 1'b0;
    end
    else
    begin
      fetch_valid <= fetch_req;
      fetch_data <= fetch_req ? next_fetch_data : fetch_data;
      fetch_in_nop_area <= fetch_req ? fetch_nop : fetch_in_nop_area;
    end
  end

endmodule
`default_nettype wire

// File: testbench/code_mem_model.sv
// Purpose: Code memories that the fetch path reads from.
// Assumes: Read data is valid in the cycle of the address.
// Notes: Flash space above F7FFH holds an address pattern that is zero at some addresses (F85DH), so a NOP seen there need not come from the block.
`timescale 1ns/1ps
`default_nettype none
module code_mem_model
(
  input wire logic [15:0] addr,
  output logic [7:0] flash_data,
  output logic [7:0] ext_data
);
  assign flash_data = addr[7:0] ^ addr[15:8] ^ 8'hA5;
  assign ext_data = addr[7:0] + 8'h11;
endmodule
`default_nettype wire

// File: testbench/memory_map_stack_properties.sv
// Purpose: Port assertions for the memory map and stack block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to every instance of the top module.
`timescale 1ns/1ps
`default_nettype none
module memory_map_stack_properties
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ext_code_select_n,
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  input wire logic [7:0] flash_rdata,
  input wire logic [7:0] ext_code_rdata,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [1:0] mem_mode,
  input wire logic [7:0] mem_addr,
  input wire logic push_req,
  input wire logic pop_req,
  input wire logic code_external,
  input wire logic fetch_valid,
  input wire logic [7:0] fetch_data,
  input wire logic fetch_in_nop_area,
  input wire logic mem_rvalid,
  input wire logic sfr_fwd_req,
  input wire logic [7:0] sfr_fwd_addr,
  input wire logic pop_valid
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  logic served;
  logic nop_zone;
  assign served = mem_req && !push_req && !pop_req;
  assign nop_zone = fetch_addr >= memory_map_pkg::NOP_AREA_BASE;

  a_strap_capture:
    assert property ($fell(sys_rst) |-> code_external == !$past(ext_code_select_n)) else $error("strap not kept");
  a_code_mode_hold:
    assert property ($stable(code_external) || $fell(sys_rst)) else $error("code mode moved");
  a_fetch_answer:
    assert property (1'b1 |=> fetch_valid == $past(fetch_req)) else $error("fetch answer wrong");
  a_nop_area_fill:
    assert property (fetch_req && !code_external && nop_zone
      |=> fetch_data == memory_map_pkg::NOP_OPCODE && fetch_in_nop_area) else $error("no NOP");
  a_flash_fetch:
    assert property (fetch_req && !code_external && !nop_zone
      |=> fetch_data == $past(flash_rdata) && !fetch_in_nop_area) else $error("flash byte wrong");
  a_ext_fetch:
    assert property (fetch_req && code_external |=> fetch_data == $past(ext_code_rdata)) else $error("ext byte wrong");
  a_read_answer:
    assert property (served && !mem_we |=> mem_rvalid) else $error("read not answered");
  a_sfr_forward:
    assert property (served && mem_mode == 2'b00 && mem_addr[7] && !(mem_addr inside {8'h81, 8'hB7, 8'hAF})
      |=> sfr_fwd_req && sfr_fwd_addr == $past(mem_addr)) else $error("not forwarded");
  a_ram_no_forward:
    assert property (served && (mem_mode != 2'b00 || !mem_addr[7]) |=> !sfr_fwd_req) else $error("bad forward");
  a_pop_answer:
    assert property (1'b1 |=> pop_valid == $past(pop_req && !push_req)) else $error("pop answer wrong");

  c_nop_fetch: cover property (fetch_req && !code_external && nop_zone);
  c_forward: cover property (served && mem_mode == 2'b00 && mem_addr[7]);
  c_pop: cover property (pop_req && !push_req);
endmodule
bind memory_map_stack memory_map_stack_properties chk (.clock, .sys_rst, .ext_code_select_n, .fetch_req,
  .fetch_addr, .flash_rdata, .ext_code_rdata, .mem_req, .mem_we, .mem_mode, .mem_addr, .push_req, .pop_req,
  .code_external, .fetch_valid, .fetch_data, .fetch_in_nop_area, .mem_rvalid, .sfr_fwd_req, .sfr_fwd_addr,
  .pop_valid);
`default_nettype wire

// File: testbench/memory_map_stack_tb_top.sv
// Purpose: Self-checking bench for the memory map and stack block.
// Assumes: Inputs change on the falling edge; results read one cycle later, on the next falling edge.
// Notes: Each task leaves a free cycle so no strobe is set twice in one step.
`timescale 1ns/1ps
`default_nettype none
module memory_map_stack_tb_top;
  logic clock, sys_rst, ext_code_select_n, fetch_req, mem_req, mem_we, bit_req, bit_we, bit_wdata, push_req, pop_req;
  logic [15:0] fetch_addr, a;
  logic [7:0] flash_rdata, ext_code_rdata, mem_addr, mem_wdata, push_data, rd, v;
  logic [1:0] mem_mode, mem_bank;
  logic [6:0] bit_addr;
  logic code_external, fetch_valid, fetch_in_nop_area, mem_rvalid, sfr_fwd_req, sfr_fwd_we, bit_rvalid, bit_rdata;
  logic pop_valid, stack_in_extended_data_ram;
  logic [7:0] fetch_data, mem_rdata, sfr_fwd_addr, sfr_fwd_wdata, pop_data;
  int num_errors, comparisons, cycles, seed;

  memory_map_stack DUT (.clock, .sys_rst, .ext_code_select_n, .fetch_req, .fetch_addr, .flash_rdata,
    .ext_code_rdata, .mem_req, .mem_we, .mem_mode, .mem_bank, .mem_addr, .mem_wdata, .bit_req, .bit_we,
    .bit_addr, .bit_wdata, .push_req, .push_data, .pop_req, .code_external, .fetch_valid, .fetch_data,
    .fetch_in_nop_area, .mem_rvalid, .mem_rdata, .sfr_fwd_req, .sfr_fwd_we, .sfr_fwd_addr, .sfr_fwd_wdata,
    .bit_rvalid, .bit_rdata, .pop_valid, .pop_data, .stack_in_extended_data_ram);
  code_mem_model mem (.addr(fetch_addr), .flash_data(flash_rdata), .ext_data(ext_code_rdata));

  function automatic logic [7:0] exp_code(input logic ext, input logic [15:0] ad);
    if (ext)
      return ad[7:0] + 8'h11;
    if (ad >= memory_map_pkg::NOP_AREA_BASE)
      return memory_map_pkg::NOP_OPCODE;
    return ad[7:0] ^ ad[15:8] ^ 8'hA5;
  endfunction

  task automatic stop_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rst(input logic strap);
    @(negedge clock);
    sys_rst = 1;
    ext_code_select_n = strap;
    repeat (8) @(negedge clock);
    sys_rst = 0;
  endtask

  task automatic acc(input logic we, input logic [1:0] md, input logic [7:0] ad, input logic [7:0] d);
    @(negedge clock);
    mem_req = 1;
    mem_we = we;
    mem_mode = md;
    mem_addr = ad;
    mem_wdata = d;
    @(negedge clock);
    mem_req = 0;
    rd = mem_rdata;
  endtask

  task automatic stk(input logic ps, input logic [7:0] d);
    @(negedge clock);
    push_req = ps;
    pop_req = !ps;
    push_data = d;
    @(negedge clock);
    push_req = 0;
    pop_req = 0;
    rd = pop_data;
  endtask

  task automatic fet(input logic [15:0] ad);
    @(negedge clock);
    fetch_req = 1;
    fetch_addr = ad;
    @(negedge clock);
    fetch_req = 0;
    rd = fetch_data;
  endtask

  task automatic bt(input logic we, input logic [6:0] ad, input logic d);
    @(negedge clock);
    bit_req = 1;
    bit_we = we;
    bit_addr = ad;
    bit_wdata = d;
    @(negedge clock);
    bit_req = 0;
    rd = {7'h00, bit_rdata};
  endtask

  initial
  begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end

  // Cut a hang short well beyond the roughly 150 cycles the sequence needs
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      stop_test();
    end
  end

  initial
  begin
    {num_errors, comparisons, cycles} = 0;
    seed = 32'h8552DAC2;
    {sys_rst, ext_code_select_n} = 2'b11;
    {fetch_req, mem_req, mem_we, bit_req, bit_we, bit_wdata, push_req, pop_req} = 8'h00;
    {fetch_addr, mem_addr, mem_wdata, push_data, mem_mode, mem_bank, bit_addr} = 51'h0;
    rst(1'b1);
    acc(0, 2'h0, 8'h81, 8'h00); chk(rd, 8'h07);
    acc(0, 2'h0, 8'hB7, 8'h00); chk(rd, 8'h00);
    stk(1, 8'h55); acc(0, 2'h0, 8'h81, 8'h00); chk(rd, 8'h08);
    mem_bank = 2'h1;
    acc(0, 2'h2, 8'h00, 8'h00); chk(rd, 8'h55);
    stk(0, 8'h00); chk(rd, 8'h55);
    acc(1, 2'h1, 8'h90, 8'hA5); acc(0, 2'h0, 8'h90, 8'h00); chk(rd, 8'h00);
    acc(0, 2'h1, 8'h90, 8'h00); chk(rd, 8'hA5);
    // Mode value 3 is decoded like indirect, so it must reach upper RAM too
    acc(0, 2'h3, 8'h90, 8'h00); chk(rd, 8'hA5);
    // Forwarded pulses still stand on the falling edge right after the task
    acc(1, 2'h0, 8'hC5, 8'h3A); chk({sfr_fwd_req, sfr_fwd_we, 6'h00}, 8'hC0);
    chk(sfr_fwd_addr, 8'hC5); chk(sfr_fwd_wdata, 8'h3A);
    acc(1, 2'h0, 8'h30, 8'h3C); acc(0, 2'h1, 8'h30, 8'h00); chk(rd, 8'h3C);
    acc(1, 2'h1, 8'h21, 8'h00); bt(1, 7'h0F, 1'b1);
    acc(0, 2'h1, 8'h21, 8'h00); chk(rd, 8'h80);
    bt(0, 7'h0F, 1'b0); chk(rd, 8'h01);
    chk({7'h00, bit_rvalid}, 8'h01);
    acc(1, 2'h0, 8'hB7, 8'h05); acc(1, 2'h0, 8'h81, 8'hFF); v = 8'($random(seed));
    stk(1, v); acc(0, 2'h0, 8'h81, 8'h00); chk(rd, 8'h00);
    acc(0, 2'h1, 8'h00, 8'h00); chk(rd, v);
    acc(0, 2'h0, 8'hB7, 8'h00); chk(rd, 8'h05);
    acc(1, 2'h0, 8'hAF, 8'h80); acc(1, 2'h0, 8'hB7, 8'h00); acc(1, 2'h0, 8'h81, 8'hFF);
    stk(1, 8'h99); acc(0, 2'h0, 8'h81, 8'h00); chk(rd, 8'h00);
    acc(0, 2'h0, 8'hB7, 8'h00); chk(rd, 8'h01);
    chk({7'h00, stack_in_extended_data_ram}, 8'h01);
    stk(0, 8'h00); chk(rd, 8'h99);
    acc(0, 2'h0, 8'hB7, 8'h00); chk(rd, 8'h00);
    acc(1, 2'h0, 8'hB7, 8'hFF); acc(0, 2'h0, 8'hB7, 8'h00); chk(rd, 8'h07);
    acc(1, 2'h0, 8'h81, 8'hFE); stk(1, 8'hAB); stk(0, 8'h00); chk(rd, 8'hAB);
    fet(16'hF7FF); chk(rd, exp_code(1'b0, 16'hF7FF));
    fet(16'hF800); chk(rd, exp_code(1'b0, 16'hF800));
    fet(16'hFFFF); chk(rd, exp_code(1'b0, 16'hFFFF));
    for (int i = 0; i < 16; i++)
    begin
      a = 16'($random(seed));
      fet(a); chk(rd, exp_code(1'b0, a));
    end
    rst(1'b0);
    chk({7'h00, code_external}, 8'h01);
    for (int i = 0; i < 8; i++)
    begin
      a = 16'($random(seed)) | 16'hF800;
      fet(a); chk(rd, exp_code(1'b1, a));
    end
    stop_test();
  end
endmodule
`default_nettype wire
